// >>> inc/cta_pkg.sv
// cta_pkg: constants and carrier types for the counter A timer block.
// assumes one CPU byte bus and one shared port pin around the block.
`default_nettype none

package cta_pkg;

    // counter and latch geometry
    localparam int unsigned CNT_W    = 16;
    localparam int unsigned BYTE_W   = 8;
    localparam int unsigned ADDR_W   = 16;

    // bus addresses of the three byte registers
    localparam logic [15:0] ADDR_LOW_CLR  = 16'h0018;
    localparam logic [15:0] ADDR_HIGH     = 16'h0019;
    localparam logic [15:0] ADDR_LOW_LOAD = 16'h001A;

    // reset values
    localparam logic [15:0] CNT_RST      = 16'h0000;
    localparam logic [15:0] LATCH_RST    = 16'h0000;
    localparam logic [7:0]  RDATA_RST    = 8'h00;
    localparam logic        PIN_OUT_RST  = 1'b1;

    // counter zero and serial divide (bit rate is 1/16 of underflow rate)
    localparam logic [15:0] CNT_ZERO     = 16'h0000;
    localparam int unsigned BAUD_DIV     = 16;
    localparam int unsigned BAUD_W       = 4;
    localparam logic [3:0]  BAUD_LAST    = 4'(BAUD_DIV - 1);

    // mode codes, high mode bit first
    typedef enum logic [1:0] {
        MODE_INTERVAL = 2'h0,
        MODE_PULSE    = 2'h1,
        MODE_EVENT    = 2'h2,
        MODE_WIDTH    = 2'h3
    } cta_mode_e;

    localparam cta_mode_e MODE_RST = MODE_INTERVAL;

    // cpu side bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
    } cta_bus_s;

    // the whole state of the timer
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] latch;
        logic        flag;
        logic        irq;
        cta_mode_e   mode;
        logic        pin_prev;
        logic        pin_out;
        logic        io_o;
        logic        io_oe;
        logic [7:0]  rdata;
        logic [3:0]  baud_cnt;
        logic        baud_tick;
    } cta_state_s;

endpackage

`default_nettype wire

// >>> hw/cta_timer.sv
// cta_timer: 16-bit down counter with reload latch, four modes, serial
// bit-rate tick. assumes a synchronous byte bus and a sampled pin input.
//
// Function
// - 16-bit down counter with 16-bit reload latch
// - reads return high or low counter byte
// - low-byte read at 0018 clears underflow flag
// - writes at 0019/0018 fill latch bytes only
// - write 001A fills high latch, loads counter
// - decrement past zero reloads latch, sets flag
// - flag clears on 0018 read, 001A write, reset
// - two mode bits select one of four modes
// - reset selects interval timer mode
// - clock modes decrement every system clock
// - flag with enable raises interrupt request
// - interval mode leaves pin as port bit
// - pulse mode pin toggles on each underflow
// - pulse entry drives high, load drives low
// - event mode counts pin rising edges
// - width mode counts while pin low, holds high
// - width mode reloads at zero, keeps counting
// - serial enable forces internal clock counting
// - serial bit rate is underflow rate/16
`timescale 1ns/1ns
`default_nettype none

module cta_timer
(
    // clock, reset, enable
    input  wire logic        MCLK,
    input  wire logic        SRST,
    input  wire logic        CE,
    // cpu byte bus
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        RD,
    input  wire logic        WR,
    output logic      [7:0]  RDATA,
    // mode and interrupt control
    input  wire logic        TIMER_MODE_BIT_HIGH,
    input  wire logic        TIMER_MODE_BIT_LOW,
    input  wire logic        TIMER_IRQ_ENABLE,
    input  wire logic        SERIAL_INT_CLK_EN,
    output logic             TIMER_UNDERFLOW_FLAG,
    output logic             IRQ,
    // shared pin and its port bit
    input  wire logic        PORT_BIT_FOUR_O,
    input  wire logic        PORT_BIT_FOUR_OE,
    input  wire logic        TIMER_IO_PIN_I,
    output logic             TIMER_IO_PIN_O,
    output logic             TIMER_IO_PIN_OE,
    // serial bit-rate strobe
    output logic             SERIAL_BIT_TICK
);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic hit
    (
        input cta_pkg::cta_bus_s b,
        input logic [15:0]       a,
        input logic              is_wr
    );
        hit = (b.addr == a) && (is_wr ? b.wr : b.rd);
    endfunction

    cta_pkg::cta_bus_s  bus;
    cta_pkg::cta_state_s st_r;
    cta_pkg::cta_state_s st_nxt;
    cta_pkg::cta_mode_e mode_in;
    cta_pkg::cta_mode_e mode_eff;
    logic               rise;
    logic               dec;
    logic               uflow;
    logic               rd_clr;
    logic               wr_load;

    assign bus.addr  = ADDR;
    assign bus.wdata = WDATA;
    assign bus.rd    = RD;
    assign bus.wr    = WR;

    assign mode_in = cta_pkg::cta_mode_e'({TIMER_MODE_BIT_HIGH,
                                           TIMER_MODE_BIT_LOW});

    assign mode_eff = SERIAL_INT_CLK_EN ? cta_pkg::MODE_INTERVAL
                                        : st_r.mode;

    assign rise = TIMER_IO_PIN_I && !st_r.pin_prev;

    assign rd_clr  = hit(bus, cta_pkg::ADDR_LOW_CLR, 1'b0);
    assign wr_load = hit(bus, cta_pkg::ADDR_LOW_LOAD, 1'b1);

    ////////////////////////////////////////////////////////////////////////
    // count enable per mode

    always_comb
    begin
        unique case (mode_eff)
            cta_pkg::MODE_INTERVAL,
            cta_pkg::MODE_PULSE:    dec = 1'b1;
            cta_pkg::MODE_EVENT:    dec = rise;
            cta_pkg::MODE_WIDTH:    dec = !TIMER_IO_PIN_I;
        endcase
    end

    assign uflow = dec && (st_r.cnt == cta_pkg::CNT_ZERO) && !wr_load;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.mode      = mode_in;
        st_nxt.pin_prev  = TIMER_IO_PIN_I;
        st_nxt.baud_tick = 1'b0;

        if (bus.rd && bus.addr == cta_pkg::ADDR_HIGH)
            st_nxt.rdata = st_r.cnt[15:8];
        else if (rd_clr || hit(bus, cta_pkg::ADDR_LOW_LOAD, 1'b0))
            st_nxt.rdata = st_r.cnt[7:0];

        if (rd_clr)
            st_nxt.flag = 1'b0;

        if (hit(bus, cta_pkg::ADDR_HIGH, 1'b1))
            st_nxt.latch[15:8] = bus.wdata;
        if (hit(bus, cta_pkg::ADDR_LOW_CLR, 1'b1))
            st_nxt.latch[7:0] = bus.wdata;

        if (dec)
            st_nxt.cnt = st_r.cnt - 16'h0001;

        if (wr_load)
        begin
            st_nxt.latch[15:8] = bus.wdata;
            st_nxt.cnt         = {bus.wdata, st_r.latch[7:0]};
            st_nxt.flag        = 1'b0;
        end
        else if (uflow)
        begin
            st_nxt.cnt  = st_r.latch;
            st_nxt.flag = 1'b1;
        end

        if (uflow)
        begin
            if (st_r.baud_cnt == cta_pkg::BAUD_LAST)
            begin
                st_nxt.baud_cnt  = '0;
                st_nxt.baud_tick = SERIAL_INT_CLK_EN;
            end
            else
                st_nxt.baud_cnt = st_r.baud_cnt + 4'h1;
        end

        if (mode_eff != cta_pkg::MODE_PULSE)
            st_nxt.pin_out = 1'b1;
        else if (wr_load)
            st_nxt.pin_out = 1'b0;
        else if (uflow)
            st_nxt.pin_out = !st_r.pin_out;

        // pin is a port bit unless counter owns it
        unique case (mode_eff)
            cta_pkg::MODE_PULSE:
            begin
                st_nxt.io_o  = st_nxt.pin_out;
                st_nxt.io_oe = 1'b1;
            end
            cta_pkg::MODE_EVENT,
            cta_pkg::MODE_WIDTH:
            begin
                st_nxt.io_o  = PORT_BIT_FOUR_O;
                st_nxt.io_oe = 1'b0;
            end
            cta_pkg::MODE_INTERVAL:
            begin
                st_nxt.io_o  = PORT_BIT_FOUR_O;
                st_nxt.io_oe = PORT_BIT_FOUR_OE;
            end
        endcase

        st_nxt.irq = st_nxt.flag && TIMER_IRQ_ENABLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            st_r           <= '0;
            st_r.cnt       <= cta_pkg::CNT_RST;
            st_r.latch     <= cta_pkg::LATCH_RST;
            st_r.rdata     <= cta_pkg::RDATA_RST;
            st_r.pin_out   <= cta_pkg::PIN_OUT_RST;
            st_r.mode      <= cta_pkg::MODE_RST;
        end
        else if (CE)
            st_r <= st_nxt;
    end

    assign RDATA                = st_r.rdata;
    assign TIMER_UNDERFLOW_FLAG = st_r.flag;
    assign IRQ                  = st_r.irq;
    assign TIMER_IO_PIN_O       = st_r.io_o;
    assign TIMER_IO_PIN_OE      = st_r.io_oe;
    assign SERIAL_BIT_TICK      = st_r.baud_tick;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_load_start;
        @(posedge MCLK) disable iff (SRST)
        (CE && wr_load)
            |=> (st_r.cnt == {$past(WDATA), $past(st_r.latch[7:0])})
                && !st_r.flag;
    endproperty
    a_load_start: assert property (p_load_start)
        else $error("load at 001A did not start counter");

    property p_rd_clear;
        @(posedge MCLK) disable iff (SRST)
        (CE && rd_clr && !uflow) |=> !st_r.flag;
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("read at 0018 left flag set");

    property p_rd_high;
        @(posedge MCLK) disable iff (SRST)
        (CE && RD && ADDR == cta_pkg::ADDR_HIGH)
            |=> RDATA == $past(st_r.cnt[15:8]);
    endproperty
    a_rd_high: assert property (p_rd_high)
        else $error("high byte read wrong");

    property p_wr_low;
        @(posedge MCLK) disable iff (SRST)
        (CE && WR && ADDR == cta_pkg::ADDR_LOW_CLR)
            |=> st_r.latch[7:0] == $past(WDATA);
    endproperty
    a_wr_low: assert property (p_wr_low)
        else $error("low latch write lost");

    property p_reload;
        @(posedge MCLK) disable iff (SRST)
        (CE && uflow) |=> st_r.flag && st_r.cnt == $past(st_r.latch);
    endproperty
    a_reload: assert property (p_reload)
        else $error("underflow did not reload");

    property p_interval;
        @(posedge MCLK) disable iff (SRST)
        (CE && mode_eff == cta_pkg::MODE_INTERVAL && !wr_load
            && st_r.cnt != cta_pkg::CNT_ZERO)
            |=> st_r.cnt == $past(st_r.cnt) - 16'h0001;
    endproperty
    a_interval: assert property (p_interval)
        else $error("interval count step wrong");

    property p_irq;
        @(posedge MCLK) disable iff (SRST)
        (CE && st_r.flag && TIMER_IRQ_ENABLE && !rd_clr && !wr_load)
            |=> IRQ;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt request missing");

    property p_width_hold;
        @(posedge MCLK) disable iff (SRST)
        (CE && mode_eff == cta_pkg::MODE_WIDTH && TIMER_IO_PIN_I
            && !wr_load) |=> $stable(st_r.cnt);
    endproperty
    a_width_hold: assert property (p_width_hold)
        else $error("width count moved while pin high");

    property p_event_hold;
        @(posedge MCLK) disable iff (SRST)
        (CE && mode_eff == cta_pkg::MODE_EVENT && !rise && !wr_load)
            |=> $stable(st_r.cnt);
    endproperty
    a_event_hold: assert property (p_event_hold)
        else $error("event count moved without edge");

    property p_toggle;
        @(posedge MCLK) disable iff (SRST)
        (CE && mode_eff == cta_pkg::MODE_PULSE && uflow
            && $past(mode_eff) == cta_pkg::MODE_PULSE)
            |=> st_r.pin_out != $past(st_r.pin_out) ##1 1'b1;
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("pulse output did not toggle");

    property p_reset_mode;
        @(posedge MCLK) SRST |=> st_r.mode == cta_pkg::MODE_INTERVAL;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("reset did not select interval mode");

    property p_pulse_load;
        @(posedge MCLK) disable iff (SRST)
        (CE && mode_eff == cta_pkg::MODE_PULSE && wr_load)
            |=> TIMER_IO_PIN_OE && !TIMER_IO_PIN_O;
    endproperty
    a_pulse_load: assert property (p_pulse_load)
        else $error("load in pulse mode left output high");

    property p_port_bit;
        @(posedge MCLK) disable iff (SRST)
        (CE && mode_eff == cta_pkg::MODE_INTERVAL)
            |=> TIMER_IO_PIN_O == $past(PORT_BIT_FOUR_O)
                && TIMER_IO_PIN_OE == $past(PORT_BIT_FOUR_OE);
    endproperty
    a_port_bit: assert property (p_port_bit)
        else $error("interval mode pin not following port bit");

    property p_baud_tick;
        @(posedge MCLK) disable iff (SRST)
        (CE && uflow && SERIAL_INT_CLK_EN
            && st_r.baud_cnt == cta_pkg::BAUD_LAST)
            |=> SERIAL_BIT_TICK;
    endproperty
    a_baud_tick: assert property (p_baud_tick)
        else $error("serial tick missing after sixteenth underflow");

endmodule

`default_nettype wire

// >>> tb/cta_pin_src.sv
// cta_pin_src: far-side model that drives the shared timer pin.
// assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/1ns
`default_nettype none

module cta_pin_src
(
    // clock
    input  wire logic clk,
    // level offered to the pin
    output var  logic lvl
);
    initial lvl = 1'b0;

    ////////////////////////////////////////////////////////////////////
    task automatic hold(input logic v, input int n);
        lvl = v;
        repeat (n) @(negedge clk);
    endtask

    // one rising edge per two clocks
    // fastest legal rate, so no event may be lost
    task automatic events(input int n);
        repeat (n)
        begin
            hold(1'b1, 1);
            hold(1'b0, 1);
        end
    endtask
endmodule

`default_nettype wire

// >>> tb/testbench.sv
// testbench: self-checking bench for the counter timer block.
// assumes cta_pkg, cta_timer and cta_pin_src are compiled first.
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic        mclk;
    logic        srst    = 1'b1;
    logic        ce      = 1'b1;
    logic [15:0] addr    = 16'h0000;
    logic [7:0]  wdata   = 8'h00;
    logic        rd      = 1'b0;
    logic        wr      = 1'b0;
    logic        mode_hi = 1'b0;
    logic        mode_lo = 1'b0;
    logic        irq_en  = 1'b1;
    logic        ser_en  = 1'b0;
    logic        port_o  = 1'b1;
    logic        port_oe = 1'b0;
    logic [7:0]  rdata;
    logic        flag;
    logic        irq;
    logic        pin_o;
    logic        pin_oe;
    logic        tick;
    logic        src_lvl;
    logic        pin_i;
    int          n_mismatch = 0;
    int          checked    = 0;
    int          n_tick;
    // lo, hi, low byte at once, high byte one clock later
    // last row is the 9600 baud reload at a 2 MHz clock
    logic [31:0] rows [7] = '{32'h34123412, 32'h00010000, 32'hFFFFFFFF,
                              32'h01000100, 32'h00000000, 32'h0080007F,
                              32'h0C000C00};

    // timer drive wins, then the port bit, then the outside source
    assign pin_i = pin_oe ? pin_o : (port_oe ? port_o : src_lvl);

    cta_pin_src u_src (.clk(mclk), .lvl(src_lvl));

    cta_timer u_cta_timer
    (
        .MCLK                 (mclk),
        .SRST                 (srst),
        .CE                   (ce),
        .ADDR                 (addr),
        .WDATA                (wdata),
        .RD                   (rd),
        .WR                   (wr),
        .RDATA                (rdata),
        .TIMER_MODE_BIT_HIGH  (mode_hi),
        .TIMER_MODE_BIT_LOW   (mode_lo),
        .TIMER_IRQ_ENABLE     (irq_en),
        .SERIAL_INT_CLK_EN    (ser_en),
        .TIMER_UNDERFLOW_FLAG (flag),
        .IRQ                  (irq),
        .PORT_BIT_FOUR_O      (port_o),
        .PORT_BIT_FOUR_OE     (port_oe),
        .TIMER_IO_PIN_I       (pin_i),
        .TIMER_IO_PIN_O       (pin_o),
        .TIMER_IO_PIN_OE      (pin_oe),
        .SERIAL_BIT_TICK      (tick)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // strobes stay up until idle, so back-to-back calls never glitch
    task automatic bus(input logic r, input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        rd = r;
        wr = w;
        addr = a;
        wdata = d;
        @(negedge mclk);
    endtask

    task automatic idle(input int n);
        rd = 1'b0;
        wr = 1'b0;
        repeat (n) @(negedge mclk);
    endtask

    task automatic rd8(input logic [15:0] a, input logic [7:0] e);
        bus(1'b1, 1'b0, a, 8'h00);
        chk(rdata, e);
    endtask

    task automatic load(input logic [7:0] lo, input logic [7:0] hi);
        bus(1'b0, 1'b1, cta_pkg::ADDR_LOW_CLR, lo);
        bus(1'b0, 1'b1, cta_pkg::ADDR_LOW_LOAD, hi);
    endtask

    task automatic rst_chk;
        chk({flag, irq, pin_oe, tick, 4'h0}, 8'h00);
        chk(rdata, cta_pkg::RDATA_RST);
    endtask

    task automatic summarize;
        if (n_mismatch == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial
    begin
        repeat (3000) @(posedge mclk);
        n_mismatch++;
        summarize();
    end

    initial
    begin
        repeat (4) @(negedge mclk);
        rst_chk();
        srst = 1'b0;
        idle(1);
        port_oe = 1'b1;
        port_o  = 1'b0;
        idle(1);
        chk({6'h00, pin_oe, pin_o}, 8'h02);
        port_oe = 1'b0;
        idle(1);
        chk({7'h00, pin_oe}, 8'h00);
        foreach (rows[i])
        begin
            load(rows[i][31:24], rows[i][23:16]);
            rd8(cta_pkg::ADDR_LOW_LOAD, rows[i][15:8]);
            rd8(cta_pkg::ADDR_HIGH, rows[i][7:0]);
        end
        // latch writes leave the running count alone
        load(8'h00, 8'h10);
        bus(1'b0, 1'b1, cta_pkg::ADDR_HIGH, 8'hAA);
        bus(1'b0, 1'b1, cta_pkg::ADDR_LOW_CLR, 8'h55);
        rd8(cta_pkg::ADDR_LOW_LOAD, 8'hFE);
        bus(1'b0, 1'b1, cta_pkg::ADDR_LOW_LOAD, 8'h77);
        rd8(cta_pkg::ADDR_HIGH, 8'h77);
        rd8(cta_pkg::ADDR_LOW_LOAD, 8'h54);
        // underflow, flag and interrupt
        load(8'h03, 8'h00);
        chk({7'h00, flag}, 8'h00);
        idle(3);
        chk({7'h00, flag}, 8'h00);
        idle(1);
        chk({6'h00, flag, irq}, 8'h03);
        rd8(cta_pkg::ADDR_LOW_LOAD, 8'h03);
        chk({7'h00, flag}, 8'h01);
        rd8(cta_pkg::ADDR_LOW_CLR, 8'h02);
        chk({7'h00, flag}, 8'h00);
        irq_en = 1'b0;
        idle(2);
        chk({6'h00, flag, irq}, 8'h02);
        // pulse output: park a long count first so entry is not toggled
        load(8'hFF, 8'hFF);
        idle(1);
        mode_lo = 1'b1;
        idle(2);
        chk({6'h00, pin_oe, pin_o}, 8'h03);
        load(8'h02, 8'h00);
        chk({6'h00, pin_oe, pin_o}, 8'h02);
        idle(2);
        chk({6'h00, pin_oe, pin_o}, 8'h02);
        idle(1);
        chk({6'h00, pin_oe, pin_o}, 8'h03);
        // event counting
        mode_hi = 1'b1;
        mode_lo = 1'b0;
        idle(2);
        load(8'h05, 8'h00);
        idle(1);
        u_src.events(3);
        idle(2);
        rd8(cta_pkg::ADDR_LOW_LOAD, 8'h02);
        u_src.events(3);
        idle(2);
        chk({7'h00, flag}, 8'h01);
        rd8(cta_pkg::ADDR_LOW_LOAD, 8'h05);
        // low-pulse width
        mode_lo = 1'b1;
        u_src.hold(1'b1, 2);
        load(8'h03, 8'h00);
        idle(2);
        u_src.hold(1'b0, 2);
        u_src.hold(1'b1, 2);
        rd8(cta_pkg::ADDR_LOW_LOAD, 8'h01);
        u_src.hold(1'b0, 2);
        u_src.hold(1'b1, 2);
        chk({7'h00, flag}, 8'h01);
        rd8(cta_pkg::ADDR_LOW_LOAD, 8'h03);
        rd8(16'h0118, 8'h03);
        chk({7'h00, flag}, 8'h01);
        srst = 1'b1;
        idle(2);
        rst_chk();
        srst = 1'b0;
        // serial forcing: pin held high would otherwise stop the count
        ser_en = 1'b1;
        // 62.5K bps at a 2 MHz clock: 2000000/(16*62500) - 1 = 1
        load(8'h01, 8'h00);
        idle(4);
        n_tick = 0;
        repeat (96)
        begin
            idle(1);
            if (tick === 1'b1)
                n_tick++;
        end
        chk(8'(n_tick), 8'h03);
        ser_en  = 1'b0;
        mode_hi = 1'b0;
        mode_lo = 1'b0;
        idle(2);
        load(8'h00, 8'h01);
        ce = 1'b0;
        idle(5);
        ce = 1'b1;
        rd8(cta_pkg::ADDR_HIGH, 8'h01);
        summarize();
    end
endmodule

`default_nettype wire
